//--- pdma_pkg.sv
/*
 * Shared constants and carriers for the peripheral DMA unit:
 * per-channel register offsets, field positions, reset values, state type.
 * Assumes a 64-byte register window per channel, word-aligned registers.
 */
package pdma_pkg;
	localparam int WIN_BITS = 6;
	localparam int CNT_W = 16;
	localparam int SIZE_W = 2;
	localparam int FLAG_W = 3;

	localparam logic [5:0] OFF_MPTR = 6'h00;
	localparam logic [5:0] OFF_PSEL = 6'h04;
	localparam logic [5:0] OFF_CNT = 6'h08;
	localparam logic [5:0] OFF_MPTR_RLD = 6'h0C;
	localparam logic [5:0] OFF_CNT_RLD = 6'h10;
	localparam logic [5:0] OFF_CMD = 6'h14;
	localparam logic [5:0] OFF_WIDTH = 6'h18;
	localparam logic [5:0] OFF_STATE = 6'h1C;
	localparam logic [5:0] OFF_IEN_SET = 6'h20;
	localparam logic [5:0] OFF_IEN_CLR = 6'h24;
	localparam logic [5:0] OFF_IMASK = 6'h28;
	localparam logic [5:0] OFF_IFLAGS = 6'h2C;

	localparam int CMD_ON_BIT = 0;
	localparam int CMD_OFF_BIT = 1;
	localparam int CMD_ERROR_CLEAR_CMD_BIT = 8;
	localparam int FLAG_RCZ = 0;
	localparam int FLAG_TRC = 1;
	localparam int FLAG_TRANSFER_ERROR_FLAG = 2;

	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;

	localparam logic [31:0] MPTR_RST = 32'h0000_0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [1:0] SIZE_RST = 2'h0;
	localparam logic [2:0] IMASK_RST = 3'h0;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic write;
		logic [1:0] size;
	} mem_cmd_s;

	typedef enum logic {ST_IDLE, ST_MEM} xfer_state_e;
endpackage

//--- prio_pick.sv
/*
 * Fixed-priority picker: lowest set request index wins.
 * Assumes requests are stable for the cycle in which they are sampled.
 */
`timescale 1ns/1ps
module prio_pick #(
	parameter int N = 7,
	parameter int IDX_W = 3
) (
	// requests
	input wire logic [N-1:0] req,
	// result
	output logic any,
	output logic [IDX_W-1:0] idx
);
	always_comb begin
		any = |req;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = IDX_W'(i);
			end
		end
	end
endmodule // prio_pick

//--- peripheral_dma_unit.sv
/*
 * Peripheral DMA unit: NCH channels moving items between memory and a
 * peripheral holding register, programmed over APB, one memory master port.
 * Assumes a peripheral drops its request within one cycle of its ack, and
 * the memory port answers every request with one done or error pulse.
 */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - a failed memory access sets that channel's error flag and halts only it
// - a halted channel stays stopped until a one is written to error clear
// - an enabled error interrupt source raises the channel interrupt on error
// - each channel owns a 64-byte window starting at channel times 0x040
// - memory pointer holds next memory address and advances with transfers
// - peripheral identifier picks handshake, direction and holding register
// - peripheral identifier width is a design parameter
// - item counter is 16 bits and shows items remaining
// - at counter zero with nonzero reload, pointer takes the pointer reload value
// - at counter zero with nonzero reload, counter takes the reload value
// - reloading the counter clears the counter reload register
// - counter and reload both zero means no further transfers
// - pointer reload register is a full 32-bit next buffer address
// - all registers reset to zero except peripheral select, set per device; the interrupt flags register reads 0x3 after reset
// - pointer advances by one, two or four for byte, halfword or word
// - lowest numbered requesting channel is served first
// - enabled channel starts once counter or counter reload gets nonzero
// - transfer complete flag is set exactly when counter and reload are zero
module peripheral_dma_unit #(
	parameter int NCH = 7,
	parameter int PID_W = 4,
	parameter int NPID = 14,
	parameter int TX_PID_BASE = 7,
	parameter int ADDR_W = 9
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral handshake, indexed by peripheral identifier
	input wire logic [NPID-1:0] periphReq,
	input wire logic [31:0] periphRdata,
	output logic [NPID-1:0] periphAck,
	output logic [PID_W-1:0] periphId,
	output logic [31:0] periphWdata,
	output logic periphWrite,
	// memory master
	output logic memReq,
	output pdma_pkg::mem_cmd_s memCmd,
	input wire logic memDone,
	input wire logic memErr,
	input wire logic [31:0] memRdata,
	// per-channel interrupt
	output logic [NCH-1:0] irq
);
	localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;

	logic [31:0] mptr_r [NCH];
	logic [31:0] mptrRld_r [NCH];
	logic [15:0] cnt_r [NCH];
	logic [15:0] cntRld_r [NCH];
	logic [PID_W-1:0] pid_r [NCH];
	logic [1:0] size_r [NCH];
	logic [2:0] imask_r [NCH];
	logic [2:0] flags [NCH];
	logic [NCH-1:0] on_r;
	logic [NCH-1:0] transfer_error_flag_r;
	logic [NCH-1:0] elig;
	logic [NCH-1:0] irq_r;
	logic anyElig;
	logic [CH_W-1:0] pick;
	logic [CH_W-1:0] chan_r;
	pdma_pkg::xfer_state_e st_r;
	logic memReq_r;
	pdma_pkg::mem_cmd_s memCmd_r;
	logic [NPID-1:0] periphAck_r;
	logic [PID_W-1:0] periphId_r;
	logic [31:0] periphWdata_r;
	logic periphWrite_r;
	logic txDir_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] rdVal;
	logic [ADDR_W-7:0] chSel;
	logic [5:0] off;
	logic mapped;
	logic swWr;
	logic xferDone;
	logic xferErr;

	function automatic logic [31:0] stepOf(input logic [1:0] sz);
		if (sz == pdma_pkg::SIZE_BYTE) begin
			return 32'h0000_0001;
		end else if (sz == pdma_pkg::SIZE_HALF) begin
			return 32'h0000_0002;
		end
		return 32'h0000_0004;
	endfunction

	// narrow items carry zeros above their size
	function automatic logic [31:0] fitTo(input logic [31:0] d, input logic [1:0] sz);
		if (sz == pdma_pkg::SIZE_BYTE) begin
			return {24'h00_0000, d[7:0]};
		end else if (sz == pdma_pkg::SIZE_HALF) begin
			return {16'h0000, d[15:0]};
		end
		return d;
	endfunction

	assign chSel = paddr[ADDR_W-1:pdma_pkg::WIN_BITS];
	assign off = {paddr[5:2], 2'b00};
	assign mapped = (int'(chSel) < NCH) && (off <= pdma_pkg::OFF_IFLAGS);
	// writes land only at the edge that completes the access
	assign swWr = psel && penable && pready_r && pwrite && mapped;
	assign xferDone = (st_r == pdma_pkg::ST_MEM) && memDone && !memErr;
	assign xferErr = (st_r == pdma_pkg::ST_MEM) && memErr;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gChan
			assign flags[g][pdma_pkg::FLAG_RCZ] = (cntRld_r[g] == 16'h0000);
			assign flags[g][pdma_pkg::FLAG_TRC] = (cnt_r[g] == 16'h0000) && (cntRld_r[g] == 16'h0000);
			assign flags[g][pdma_pkg::FLAG_TRANSFER_ERROR_FLAG] = transfer_error_flag_r[g];
			// request line chosen by the identifier
			assign elig[g] = on_r[g] && !transfer_error_flag_r[g] && (cnt_r[g] != 16'h0000)
				&& (int'(pid_r[g]) < NPID) && periphReq[pid_r[g]];
		end
	endgenerate

	prio_pick #(
		.N(NCH),
		.IDX_W(CH_W)
	) uPick (
		.req(elig),
		.any(anyElig),
		.idx(pick)
	);

	// apb answers after one wait state so that read data comes from a flop
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && !mapped;
			prdata_r <= rdVal;
		end
	end

	always_comb begin
		rdVal = 32'h0000_0000;
		if (mapped && !pwrite) begin
			unique case (off)
				pdma_pkg::OFF_MPTR: rdVal = mptr_r[chSel];
				pdma_pkg::OFF_PSEL: rdVal = {{(32-PID_W){1'b0}}, pid_r[chSel]};
				pdma_pkg::OFF_CNT: rdVal = {16'h0000, cnt_r[chSel]};
				pdma_pkg::OFF_MPTR_RLD: rdVal = mptrRld_r[chSel];
				pdma_pkg::OFF_CNT_RLD: rdVal = {16'h0000, cntRld_r[chSel]};
				pdma_pkg::OFF_WIDTH: rdVal = {30'h0000_0000, size_r[chSel]};
				pdma_pkg::OFF_STATE: rdVal = {31'h0000_0000, on_r[chSel]};
				pdma_pkg::OFF_IMASK: rdVal = {29'h0000_0000, imask_r[chSel]};
				pdma_pkg::OFF_IFLAGS: rdVal = {29'h0000_0000, flags[chSel]};
				default: rdVal = 32'h0000_0000;
			endcase
		end
	end

	// channel registers; a software write in the same cycle beats the transfer update
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!resetn) begin
				mptr_r[i] <= pdma_pkg::MPTR_RST;
				mptrRld_r[i] <= pdma_pkg::MPTR_RST;
				cnt_r[i] <= pdma_pkg::CNT_RST;
				cntRld_r[i] <= pdma_pkg::CNT_RST;
				pid_r[i] <= PID_W'(i); // per-device default: channel number
				size_r[i] <= pdma_pkg::SIZE_RST;
				imask_r[i] <= pdma_pkg::IMASK_RST;
				on_r[i] <= 1'b0;
			end else begin
				if (xferDone && int'(chan_r) == i) begin
					if (cnt_r[i] == 16'h0001 && cntRld_r[i] != 16'h0000) begin
						mptr_r[i] <= mptrRld_r[i];
						cnt_r[i] <= cntRld_r[i];
						cntRld_r[i] <= 16'h0000;
					end else begin
						mptr_r[i] <= mptr_r[i] + stepOf(size_r[i]);
						cnt_r[i] <= cnt_r[i] - 16'h0001;
					end
				end
				if (swWr && int'(chSel) == i) begin
					unique case (off)
						pdma_pkg::OFF_MPTR: mptr_r[i] <= pwdata;
						pdma_pkg::OFF_PSEL: pid_r[i] <= pwdata[PID_W-1:0];
						pdma_pkg::OFF_CNT: cnt_r[i] <= pwdata[15:0];
						pdma_pkg::OFF_MPTR_RLD: mptrRld_r[i] <= pwdata;
						pdma_pkg::OFF_CNT_RLD: begin
							// idle counter takes the reload at once
							if (cnt_r[i] == 16'h0000) begin
								cnt_r[i] <= pwdata[15:0];
								mptr_r[i] <= mptrRld_r[i];
								cntRld_r[i] <= 16'h0000;
							end else begin
								cntRld_r[i] <= pwdata[15:0];
							end
						end
						pdma_pkg::OFF_CMD: begin
							// disable wins when both bits are written
							if (pwdata[pdma_pkg::CMD_OFF_BIT]) begin
								on_r[i] <= 1'b0;
							end else if (pwdata[pdma_pkg::CMD_ON_BIT]) begin
								on_r[i] <= 1'b1;
							end
						end
						pdma_pkg::OFF_WIDTH: size_r[i] <= pwdata[1:0];
						pdma_pkg::OFF_IEN_SET: imask_r[i] <= imask_r[i] | pwdata[2:0];
						pdma_pkg::OFF_IEN_CLR: imask_r[i] <= imask_r[i] & ~pwdata[2:0];
						default: ;
					endcase
				end
			end
		end
	end

	// error flag: a fresh error wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!resetn) begin
				transfer_error_flag_r[i] <= 1'b0;
			end else if (xferErr && int'(chan_r) == i) begin
				transfer_error_flag_r[i] <= 1'b1;
			end else if (swWr && int'(chSel) == i && off == pdma_pkg::OFF_CMD && pwdata[pdma_pkg::CMD_ERROR_CLEAR_CMD_BIT]) begin
				transfer_error_flag_r[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!resetn) begin
				irq_r[i] <= 1'b0;
			end else begin
				irq_r[i] <= |(flags[i] & imask_r[i]);
			end
		end
	end

	// one item per grant; the channel is re-arbitrated after every item
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_r <= pdma_pkg::ST_IDLE;
			chan_r <= '0;
			memReq_r <= 1'b0;
			memCmd_r <= '0;
			periphAck_r <= '0;
			periphId_r <= '0;
			periphWdata_r <= 32'h0000_0000;
			periphWrite_r <= 1'b0;
			txDir_r <= 1'b0;
		end else begin
			periphAck_r <= '0;
			periphWrite_r <= 1'b0;
			unique case (st_r)
				pdma_pkg::ST_IDLE: begin
					if (anyElig) begin
						chan_r <= pick;
						periphId_r <= pid_r[pick];
						periphAck_r[pid_r[pick]] <= 1'b1;
						txDir_r <= int'(pid_r[pick]) >= TX_PID_BASE;
						memReq_r <= 1'b1;
						memCmd_r.addr <= mptr_r[pick];
						memCmd_r.write <= !(int'(pid_r[pick]) >= TX_PID_BASE);
						memCmd_r.size <= size_r[pick];
						memCmd_r.wdata <= fitTo(periphRdata, size_r[pick]);
						st_r <= pdma_pkg::ST_MEM;
					end
				end
				pdma_pkg::ST_MEM: begin
					if (memDone || memErr) begin
						memReq_r <= 1'b0;
						st_r <= pdma_pkg::ST_IDLE;
						if (!memErr && txDir_r) begin
							periphWdata_r <= fitTo(memRdata, memCmd_r.size);
							periphWrite_r <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign periphAck = periphAck_r;
	assign periphId = periphId_r;
	assign periphWdata = periphWdata_r;
	assign periphWrite = periphWrite_r;
	assign memReq = memReq_r;
	assign memCmd = memCmd_r;
	assign irq = irq_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence doneOrdinary;
		xferDone && cnt_r[chan_r] > 16'h0001 && !swWr;
	endsequence
	sequence doneReload;
		xferDone && cnt_r[chan_r] == 16'h0001 && cntRld_r[chan_r] != 16'h0000 && !swWr;
	endsequence

	err_halts_chan_a: assert property (xferErr |=> transfer_error_flag_r[chan_r] && st_r == pdma_pkg::ST_IDLE)
		else $error("error did not halt the channel");
	halted_not_served_a: assert property (st_r == pdma_pkg::ST_MEM |-> !transfer_error_flag_r[chan_r])
		else $error("halted channel was served");
	err_irq_raised_a: assert property ((xferErr && imask_r[chan_r][pdma_pkg::FLAG_TRANSFER_ERROR_FLAG] && !swWr)
		|-> ##2 irq[$past(chan_r, 2)])
		else $error("error interrupt missing");
	ptr_step_a: assert property (doneOrdinary
		|=> mptr_r[chan_r] == $past(mptr_r[chan_r]) + stepOf(size_r[chan_r]))
		else $error("pointer step wrong");
	count_down_a: assert property (doneOrdinary |=> cnt_r[chan_r] == $past(cnt_r[chan_r]) - 16'h0001)
		else $error("counter did not decrement");
	reload_swap_a: assert property (doneReload |=> cnt_r[chan_r] == $past(cntRld_r[chan_r])
		&& cntRld_r[chan_r] == 16'h0000 && mptr_r[chan_r] == $past(mptrRld_r[chan_r]))
		else $error("reload did not take place");
	grant_nonzero_a: assert property ((st_r == pdma_pkg::ST_IDLE && anyElig)
		|=> memReq && st_r == pdma_pkg::ST_MEM && cnt_r[chan_r] != 16'h0000)
		else $error("channel with zero count granted");
	lowest_first_a: assert property ((st_r == pdma_pkg::ST_IDLE && elig[0]) |=> chan_r == '0 && periphAck != '0)
		else $error("channel zero not served first");
endmodule // peripheral_dma_unit

//--- periph_mem_model.sv
/*
 * Far side of the DMA unit: peripheral request lines and a memory port.
 * Assumes the unit acks one peripheral at a time and holds memReq until answered.
 */
`timescale 1ns/1ps
module periph_mem_model #(
	parameter int NPID = 14
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// bench control
	input wire logic [NPID-1:0] reqEn,
	input wire logic slow,
	// unit side
	input wire logic memReq,
	input pdma_pkg::mem_cmd_s memCmd,
	input wire logic [NPID-1:0] periphAck,
	output logic memDone,
	output logic memErr,
	output logic [31:0] memRdata,
	output logic [31:0] periphRdata,
	output logic [NPID-1:0] periphReq
);
	logic [2:0] waitCnt;
	logic [NPID-1:0] ackHold;
	logic [31:0] junk;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			waitCnt <= 3'h0;
			memDone <= 1'b0;
			memErr <= 1'b0;
			ackHold <= '0;
			junk <= 32'h5A5A_C3C3;
		end else begin
			ackHold <= periphAck;
			junk <= {junk[30:0], junk[31] ^ junk[21]};
			memDone <= 1'b0;
			memErr <= 1'b0;
			if (memReq && !memDone && !memErr) begin
				if (waitCnt == (slow ? 3'h3 : 3'h0)) begin
					waitCnt <= 3'h0;
					// top region unmapped: answered with an error
					memErr <= (memCmd.addr[31:28] == 4'hF);
					memDone <= (memCmd.addr[31:28] != 4'hF);
				end else begin
					waitCnt <= waitCnt + 3'h1;
				end
			end
		end
	end

	// request drops in the ack cycle and the one after, so no double grant
	assign periphReq = reqEn & ~periphAck & ~ackHold;
	// data outside a valid beat is noise, never a stale value
	assign memRdata = memDone ? ~memCmd.addr : junk;
	assign periphRdata = {junk[15:0], 16'hBEEF};
endmodule // periph_mem_model

//--- tb.sv
/*
 * Self-checking bench for the DMA unit: APB master, model of the far side.
 * Assumes the unit's default parameters (7 channels, 14 identifiers).
 */
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [8:0] paddr = 9'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [13:0] reqEn = 14'h0000;
	logic slow = 1'b0;
	logic [31:0] prdata, periphRdata, periphWdata, memRdata, rd;
	logic pready, pslverr, periphWrite, memReq, memDone, memErr, err;
	logic [13:0] periphReq, periphAck;
	logic [3:0] periphId;
	logic [6:0] irq;
	pdma_pkg::mem_cmd_s memCmd;
	int n_fail = 0;
	int check_count = 0;

	always #12.5 mclk = ~mclk;

	peripheral_dma_unit DUT (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periphReq(periphReq), .periphRdata(periphRdata),
		.periphAck(periphAck), .periphId(periphId), .periphWdata(periphWdata),
		.periphWrite(periphWrite), .memReq(memReq), .memCmd(memCmd), .memDone(memDone),
		.memErr(memErr), .memRdata(memRdata), .irq(irq));
	periph_mem_model far (.mclk(mclk), .resetn(resetn), .reqEn(reqEn), .slow(slow),
		.memReq(memReq), .memCmd(memCmd), .periphAck(periphAck), .memDone(memDone),
		.memErr(memErr), .memRdata(memRdata), .periphRdata(periphRdata), .periphReq(periphReq));

	task automatic conclude();
		if (n_fail == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [8:0] ra(input int ch, input logic [5:0] off);
		return 9'(ch * 64) + {3'h0, off};
	endfunction

	task automatic apb(input logic wr, input logic [8:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge mclk);
		end
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [8:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	// waits for one memory beat and judges what the unit put out with it
	task automatic xfer(input logic [31:0] adr, input logic wr, input int peripheral_identifier, input logic [1:0] sz);
		int n;
		logic [31:0] rxW;
		logic [31:0] txW;
		n = 0;
		// model's peripheral data has 0xBEEF in its low half
		rxW = (sz == pdma_pkg::SIZE_BYTE) ? 32'h0000_00EF : 32'h0000_BEEF;
		txW = ~adr;
		if (sz == pdma_pkg::SIZE_BYTE) begin
			txW = {24'h00_0000, txW[7:0]};
		end else if (sz == pdma_pkg::SIZE_HALF) begin
			txW = {16'h0000, txW[15:0]};
		end
		@(posedge mclk);
		while (memReq !== 1'b1 && n < 100) begin
			n++;
			@(posedge mclk);
		end
		chk("memReq", 32'h1, {31'h0, memReq});
		chk("memAddr", adr, memCmd.addr);
		chk("memWrite", {31'h0, wr}, {31'h0, memCmd.write});
		chk("memSize", {30'h0, sz}, {30'h0, memCmd.size});
		chk("periphId", 32'(peripheral_identifier), {28'h0, periphId});
		chk("periphAck", 32'h1 << peripheral_identifier, {18'h0, periphAck});
		if (wr) begin
			// upper half of a word is model noise, so for a word only the low half is judged
			chk("memWdata", rxW, (sz > pdma_pkg::SIZE_HALF) ? {16'h0000, memCmd.wdata[15:0]} : memCmd.wdata);
		end
		while (memReq === 1'b1) begin
			@(posedge mclk);
		end
		chk("periphWrite", {31'h0, !wr}, {31'h0, periphWrite});
		if (!wr) begin
			chk("periphWdata", txW, periphWdata);
		end
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge mclk);
			chk("memIdle", 32'h0, {31'h0, memReq});
		end
	endtask

	task automatic t_reset();
		for (int ch = 0; ch < 7; ch += 6) begin
			for (int o = 0; o < 48; o += 4) begin
				rdchk("resetValue", ra(ch, 6'(o)), (o == 4) ? 32'(ch) : ((o == 44) ? 32'h3 : 32'h0));
			end
		end
		apb(1'b0, 9'h1C0, 32'h0);
		chk("slvErrChannel", 32'h1, {31'h0, err});
		apb(1'b0, ra(0, 6'h30), 32'h0);
		chk("slvErrOffset", 32'h1, {31'h0, err});
		apb(1'b1, ra(1, 6'h08), 32'hFFFF_FFFF);
		rdchk("counterBits", ra(1, 6'h08), 32'h0000_FFFF);
		apb(1'b1, ra(1, 6'h08), 32'h0);
		apb(1'b1, ra(1, 6'h04), 32'hFFFF_FFFF);
		rdchk("pidBits", ra(1, 6'h04), 32'h0000_000F);
		apb(1'b1, ra(1, 6'h0C), 32'hA5A5_5A5A);
		rdchk("ptrReload", ra(1, 6'h0C), 32'hA5A5_5A5A);
		apb(1'b1, ra(1, 6'h0C), 32'h0);
		apb(1'b1, ra(1, 6'h1C), 32'hFFFF_FFFF);
		rdchk("stateRo", ra(1, 6'h1C), 32'h0);
		apb(1'b1, ra(0, 6'h20), 32'h2);
		repeat (2) @(posedge mclk);
		chk("irqComplete", 32'h1, {25'h0, irq});
		apb(1'b1, ra(0, 6'h24), 32'h2);
		repeat (2) @(posedge mclk);
		chk("irqOff", 32'h0, {25'h0, irq});
	endtask

	task automatic t_run(input int ch, input int peripheral_identifier, input logic [1:0] sz, input int step, input logic wr);
		logic [31:0] base;
		base = 32'h0000_1000 + 32'(ch * 256);
		apb(1'b1, ra(ch, 6'h04), 32'(peripheral_identifier));
		apb(1'b1, ra(ch, 6'h18), {30'h0, sz});
		apb(1'b1, ra(ch, 6'h00), base);
		apb(1'b1, ra(ch, 6'h08), 32'h3);
		reqEn[peripheral_identifier] <= 1'b1;
		quiet(8);
		apb(1'b1, ra(ch, 6'h14), 32'h1);
		for (int i = 0; i < 3; i++) begin
			xfer(base + 32'(i * step), wr, peripheral_identifier, sz);
		end
		quiet(10);
		rdchk("counterEnd", ra(ch, 6'h08), 32'h0);
		rdchk("pointerEnd", ra(ch, 6'h00), base + 32'(3 * step));
		rdchk("flagsEnd", ra(ch, 6'h2C), 32'h3);
		rdchk("enabled", ra(ch, 6'h1C), 32'h1);
		// both command bits: disable must win
		apb(1'b1, ra(ch, 6'h14), 32'h3);
		rdchk("disabled", ra(ch, 6'h1C), 32'h0);
		reqEn[peripheral_identifier] <= 1'b0;
	endtask

	task automatic t_reload();
		apb(1'b1, ra(0, 6'h04), 32'h3);
		apb(1'b1, ra(0, 6'h18), 32'h2);
		apb(1'b1, ra(0, 6'h00), 32'h200);
		apb(1'b1, ra(0, 6'h08), 32'h2);
		apb(1'b1, ra(0, 6'h0C), 32'h300);
		apb(1'b1, ra(0, 6'h10), 32'h2);
		rdchk("flagsBusy", ra(0, 6'h2C), 32'h0);
		reqEn[3] <= 1'b1;
		apb(1'b1, ra(0, 6'h14), 32'h1);
		xfer(32'h200, 1'b1, 3, 2'h2);
		xfer(32'h204, 1'b1, 3, 2'h2);
		xfer(32'h300, 1'b1, 3, 2'h2);
		xfer(32'h304, 1'b1, 3, 2'h2);
		quiet(10);
		rdchk("reloadCleared", ra(0, 6'h10), 32'h0);
		rdchk("flagsDone", ra(0, 6'h2C), 32'h3);
		apb(1'b1, ra(0, 6'h0C), 32'h400);
		apb(1'b1, ra(0, 6'h10), 32'h1);
		xfer(32'h400, 1'b1, 3, 2'h2);
		apb(1'b1, ra(0, 6'h14), 32'h2);
		reqEn[3] <= 1'b0;
	endtask

	task automatic t_error();
		slow <= 1'b1;
		apb(1'b1, ra(4, 6'h20), 32'h4);
		rdchk("maskSet", ra(4, 6'h28), 32'h4);
		apb(1'b1, ra(4, 6'h00), 32'hF000_0000);
		apb(1'b1, ra(4, 6'h08), 32'h1);
		reqEn[4] <= 1'b1;
		apb(1'b1, ra(4, 6'h14), 32'h1);
		xfer(32'hF000_0000, 1'b1, 4, pdma_pkg::SIZE_BYTE);
		repeat (3) @(posedge mclk);
		chk("irqOnError", 32'h10, {25'h0, irq});
		rdchk("errFlag", ra(4, 6'h2C), 32'h5);
		quiet(10);
		apb(1'b1, ra(6, 6'h04), 32'hD);
		apb(1'b1, ra(6, 6'h00), 32'h600);
		apb(1'b1, ra(6, 6'h08), 32'h1);
		reqEn[13] <= 1'b1;
		apb(1'b1, ra(6, 6'h14), 32'h1);
		xfer(32'h600, 1'b0, 13, pdma_pkg::SIZE_BYTE);
		apb(1'b1, ra(4, 6'h00), 32'h700);
		apb(1'b1, ra(4, 6'h14), 32'h100);
		xfer(32'h700, 1'b1, 4, pdma_pkg::SIZE_BYTE);
		rdchk("errCleared", ra(4, 6'h2C), 32'h3);
		apb(1'b1, ra(4, 6'h24), 32'h4);
		rdchk("maskClear", ra(4, 6'h28), 32'h0);
		chk("irqQuiet", 32'h0, {25'h0, irq});
		apb(1'b1, ra(4, 6'h14), 32'h2);
		apb(1'b1, ra(6, 6'h14), 32'h2);
		reqEn <= 14'h0000;
		slow <= 1'b0;
	endtask

	task automatic t_prio();
		apb(1'b1, ra(5, 6'h04), 32'h9);
		apb(1'b1, ra(6, 6'h04), 32'hA);
		apb(1'b1, ra(5, 6'h00), 32'h800);
		apb(1'b1, ra(6, 6'h00), 32'h900);
		apb(1'b1, ra(5, 6'h08), 32'h1);
		apb(1'b1, ra(6, 6'h08), 32'h1);
		apb(1'b1, ra(5, 6'h14), 32'h1);
		apb(1'b1, ra(6, 6'h14), 32'h1);
		reqEn <= 14'h0600;
		xfer(32'h800, 1'b0, 9, 2'h3);
		xfer(32'h900, 1'b0, 10, pdma_pkg::SIZE_BYTE);
		reqEn <= 14'h0000;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_run(1, 8, pdma_pkg::SIZE_BYTE, 1, 1'b0);
		slow <= 1'b1;
		t_run(2, 2, pdma_pkg::SIZE_HALF, 2, 1'b1);
		slow <= 1'b0;
		t_run(3, 11, 2'h2, 4, 1'b0);
		t_run(5, 12, 2'h3, 4, 1'b0);
		t_reload();
		t_error();
		t_prio();
		conclude();
	end
endmodule // tb
